// >>> common/spi_engine_pkg.sv
// Shared constants and carrier types for the byte-oriented serial transfer engine
package spi_engine_pkg;

  // ----------------------------------------------------------------
  // Data and count widths
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int COUNT_W    = 16;
  localparam int SEL_W      = 2;
  localparam int NUM_SLAVES = 4;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0]  DUMMY_BYTE      = 8'hFF;
  localparam logic [DATA_W-1:0]  SHIFT_RST       = 8'h00;
  localparam logic [COUNT_W-1:0] INDEX_RST       = 16'h0000;
  localparam logic [COUNT_W-1:0] INDEX_STEP      = 16'h0001;
  localparam logic [2:0]         LAST_BIT        = 3'h7;
  localparam logic               TX_FLAG_RST     = 1'b1;
  localparam logic               RECV_FLAG_RST   = 1'b0;
  localparam logic               LINE_IDLE       = 1'b0;
  localparam logic               MOSI_RST        = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SCK_PERIOD_NS   = 160;
  // Half of the serial clock period, rounded down, never below one cycle
  localparam int SCK_HALF_CYCLES = (SCK_PERIOD_NS / 2 / CLK_PERIOD_NS) < 1 ? 1 :
                                   (SCK_PERIOD_NS / 2 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               is_read;
    logic [SEL_W-1:0]   slave;
    logic [COUNT_W-1:0] count;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOAD,
    ST_SHIFT,
    ST_HOLD
  } state_t;

endpackage

// >>> design/byte_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
module byte_fifo #(
  parameter int WIDTH = spi_engine_pkg::DATA_W,
  parameter int DEPTH = spi_engine_pkg::FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CNT_W'(1);
    end else if (pop && !push) begin
      next_count = count - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Pointers and fill level
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      count      <= next_count;
      in_ready_o <= (next_count != FULL_CNT);
    end
  end

  // Storage needs no reset: nothing reads a slot before it is written
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

// >>> design/spi_byte_engine.sv
// Byte-oriented serial master transfer engine with counted writes and reads
//
// Contract
// - Each outgoing byte is shifted out on MOSI toward the selected slave.
// - Reads are full duplex: MISO is sampled during the same transfer that drives MOSI.
// - The serial clock pulses only while a byte is being shifted and idles low otherwise.
// - Every byte to be read is clocked in by sending an all-ones filler byte.
// - A transmit-space event marks that a byte left the buffer for shifting and no byte is loaded until one is there.
// - The transmit-space condition stays visible as a pending flag that needs no interrupt.
// - A receive-full event marks a byte in the receive register and the next read waits until it is taken.
// - The receive-full condition sets a pending flag that stays visible without any handler.
// - A write takes an unsigned 16-bit byte count and sends exactly that many bytes.
// - A read takes an unsigned 16-bit byte count and receives exactly that many bytes.
// - The source index advances by one as each byte is taken from the buffer, before its bits are shifted out.
// - The destination index advances by one after each byte received.
// - Slave selects are dedicated output pins, one per slave.
// - The select is asserted before the first clock and released only after the last byte.
module spi_byte_engine #(
  parameter int NUM_SLAVES  = spi_engine_pkg::NUM_SLAVES,
  parameter int HALF_CYCLES = spi_engine_pkg::SCK_HALF_CYCLES,
  parameter int FIFO_DEPTH  = spi_engine_pkg::FIFO_DEPTH
) (
  input  wire logic                                clock_i,
  input  wire logic                                sys_rst_i,
  input  wire logic                                cmd_valid_i,
  input  wire spi_engine_pkg::cmd_t                cmd_i,
  output logic                                     cmd_ready_o,
  output logic                                     done_o,
  input  wire logic [spi_engine_pkg::DATA_W-1:0]   tx_data_i,
  input  wire logic                                tx_valid_i,
  output logic                                     tx_ready_o,
  output logic                                     tx_empty_event_o,
  output logic                                     tx_space_flag_o,
  output logic      [spi_engine_pkg::DATA_W-1:0]   recv_data_o,
  output logic                                     rx_full_event_o,
  output logic                                     rx_byte_flag_o,
  input  wire logic                                recv_take_i,
  output logic      [spi_engine_pkg::COUNT_W-1:0]  src_index_o,
  output logic      [spi_engine_pkg::COUNT_W-1:0]  dst_index_o,
  output logic                                     sck_o,
  output logic                                     mosi_o,
  input  wire logic                                miso_i,
  output logic      [NUM_SLAVES-1:0]               sel_n_o
);

  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYCLES - 1);

  if (NUM_SLAVES < 1 || NUM_SLAVES > (1 << spi_engine_pkg::SEL_W)) begin : g_bad_slaves
    $error("spi_byte_engine slave count outside what the select field can address");
  end
  if (HALF_CYCLES < 1 || HALF_CYCLES > 65535) begin : g_bad_half
    $error("spi_byte_engine half period must be 1 to 65535 cycles");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_SLAVES-1:0] select_lines(input logic [spi_engine_pkg::SEL_W-1:0] idx);
    logic [NUM_SLAVES-1:0] lines;
    lines = '1;
    for (int i = 0; i < NUM_SLAVES; i++) begin
      if (idx == spi_engine_pkg::SEL_W'(i)) begin
        lines[i] = 1'b0;
      end
    end
    return lines;
  endfunction

  spi_engine_pkg::state_t                state;
  spi_engine_pkg::cmd_t                  cur;
  logic [spi_engine_pkg::COUNT_W-1:0]    bytes_left;
  logic [DIV_W-1:0]                      div_cnt;
  logic [2:0]                            bit_cnt;
  logic [spi_engine_pkg::DATA_W-1:0]     tx_shift;
  logic [spi_engine_pkg::DATA_W-1:0]     recv_shift;
  logic                                  miso_meta;
  logic                                  miso_s;
  logic [spi_engine_pkg::DATA_W-1:0]     fifo_data;
  logic                                  fifo_valid;
  logic                                  fifo_pop;
  logic                                  half_done;
  logic                                  byte_end;
  logic                                  tx_push;
  logic                                  read_load;

  assign half_done = (div_cnt == HALF_LAST);
  assign byte_end  = (state == spi_engine_pkg::ST_SHIFT) && half_done && sck_o &&
                     (bit_cnt == spi_engine_pkg::LAST_BIT);
  assign tx_push   = tx_valid_i && tx_ready_o;
  // A write byte is loaded only when the buffer really holds one
  assign fifo_pop  = (state == spi_engine_pkg::ST_LOAD) && (bytes_left != '0) &&
                     !cur.is_read && fifo_valid;
  // The next read waits until the previous byte has been taken
  assign read_load = (state == spi_engine_pkg::ST_LOAD) && (bytes_left != '0) &&
                     cur.is_read && !rx_byte_flag_o;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH (spi_engine_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (tx_data_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // ----------------------------------------------------------------
  // MISO synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      miso_meta <= 1'b0;
      miso_s    <= 1'b0;
    end else begin
      miso_meta <= miso_i;
      miso_s    <= miso_meta;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state       <= spi_engine_pkg::ST_IDLE;
      cur         <= '0;
      cmd_ready_o <= 1'b1;
      done_o      <= 1'b0;
      bytes_left  <= spi_engine_pkg::INDEX_RST;
      src_index_o <= spi_engine_pkg::INDEX_RST;
      dst_index_o <= spi_engine_pkg::INDEX_RST;
      div_cnt     <= '0;
      bit_cnt     <= '0;
      tx_shift    <= spi_engine_pkg::SHIFT_RST;
      recv_shift  <= spi_engine_pkg::SHIFT_RST;
      recv_data_o <= spi_engine_pkg::SHIFT_RST;
      sck_o       <= spi_engine_pkg::LINE_IDLE;
      mosi_o      <= spi_engine_pkg::MOSI_RST;
      sel_n_o     <= '1;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        spi_engine_pkg::ST_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            cur         <= cmd_i;
            bytes_left  <= cmd_i.count;
            src_index_o <= spi_engine_pkg::INDEX_RST;
            dst_index_o <= spi_engine_pkg::INDEX_RST;
            cmd_ready_o <= 1'b0;
            div_cnt     <= '0;
            // Select goes low here, two half periods and one cycle ahead of the first clock rise
            sel_n_o     <= select_lines(cmd_i.slave);
            state       <= spi_engine_pkg::ST_SETUP;
          end
        end
        spi_engine_pkg::ST_SETUP: begin
          div_cnt <= div_cnt + DIV_W'(1);
          if (half_done) begin
            div_cnt <= '0;
            state   <= spi_engine_pkg::ST_LOAD;
          end
        end
        spi_engine_pkg::ST_LOAD: begin
          div_cnt <= '0;
          bit_cnt <= '0;
          if (bytes_left == '0) begin
            state <= spi_engine_pkg::ST_HOLD;
          end else if (fifo_pop) begin
            tx_shift    <= fifo_data;
            mosi_o      <= fifo_data[spi_engine_pkg::DATA_W-1];
            src_index_o <= src_index_o + spi_engine_pkg::INDEX_STEP;
            bytes_left  <= bytes_left - spi_engine_pkg::INDEX_STEP;
            state       <= spi_engine_pkg::ST_SHIFT;
          end else if (read_load) begin
            tx_shift   <= spi_engine_pkg::DUMMY_BYTE;
            mosi_o     <= spi_engine_pkg::DUMMY_BYTE[spi_engine_pkg::DATA_W-1];
            bytes_left <= bytes_left - spi_engine_pkg::INDEX_STEP;
            state      <= spi_engine_pkg::ST_SHIFT;
          end
        end
        spi_engine_pkg::ST_SHIFT: begin
          div_cnt <= div_cnt + DIV_W'(1);
          if (half_done) begin
            div_cnt <= '0;
            if (!sck_o) begin
              // Rising edge: sample MISO while MOSI is stable, mode 0
              sck_o      <= 1'b1;
              recv_shift <= {recv_shift[spi_engine_pkg::DATA_W-2:0], miso_s};
            end else begin
              sck_o <= 1'b0;
              if (bit_cnt == spi_engine_pkg::LAST_BIT) begin
                state <= spi_engine_pkg::ST_LOAD;
                if (cur.is_read) begin
                  recv_data_o <= recv_shift;
                  dst_index_o <= dst_index_o + spi_engine_pkg::INDEX_STEP;
                end
              end else begin
                tx_shift <= {tx_shift[spi_engine_pkg::DATA_W-2:0], 1'b0};
                mosi_o   <= tx_shift[spi_engine_pkg::DATA_W-2];
                bit_cnt  <= bit_cnt + 3'h1;
              end
            end
          end
        end
        spi_engine_pkg::ST_HOLD: begin
          div_cnt <= div_cnt + DIV_W'(1);
          if (half_done) begin
            div_cnt     <= '0;
            sel_n_o     <= '1;
            done_o      <= 1'b1;
            cmd_ready_o <= 1'b1;
            state       <= spi_engine_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Events and pending flags
  // ----------------------------------------------------------------
  // Flags are plain levels so a poller sees them with no interrupt path at all
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_empty_event_o <= 1'b0;
      rx_full_event_o  <= 1'b0;
      tx_space_flag_o  <= spi_engine_pkg::TX_FLAG_RST;
      rx_byte_flag_o   <= spi_engine_pkg::RECV_FLAG_RST;
    end else begin
      tx_empty_event_o <= fifo_pop;
      rx_full_event_o  <= byte_end && cur.is_read;
      // Set wins over the clear in the same cycle
      if (fifo_pop) begin
        tx_space_flag_o <= 1'b1;
      end else if (tx_push) begin
        tx_space_flag_o <= 1'b0;
      end
      if (byte_end && cur.is_read) begin
        rx_byte_flag_o <= 1'b1;
      end else if (recv_take_i) begin
        rx_byte_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] rise_cnt;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rise_cnt <= '0;
    end else if (state == spi_engine_pkg::ST_LOAD) begin
      rise_cnt <= '0;
    end else if (state == spi_engine_pkg::ST_SHIFT && half_done && !sck_o) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_accept;
    cmd_valid_i && cmd_ready_o;
  endsequence

  sequence s_read_byte_end;
    byte_end && cur.is_read;
  endsequence

  property p_select_first;
    s_accept |=> !(&sel_n_o) && !sck_o && !cmd_ready_o;
  endproperty

  property p_recv_publish;
    s_read_byte_end |=> rx_full_event_o && rx_byte_flag_o && (recv_data_o == $past(recv_shift))
                        ##1 !rx_full_event_o;
  endproperty

  chk_one_select: assert property ($onehot0(~sel_n_o))
    else $error("more than one slave select asserted");

  chk_clock_idle: assert property (state != spi_engine_pkg::ST_SHIFT |-> !sck_o)
    else $error("serial clock high outside a byte");

  chk_filler_ones: assert property ((state == spi_engine_pkg::ST_SHIFT && cur.is_read) |-> mosi_o)
    else $error("read filler bit not one");

  chk_select_before: assert property (p_select_first)
    else $error("select not asserted ahead of clocking");

  chk_clock_selected: assert property ($rose(sck_o) |-> !(&sel_n_o))
    else $error("clock edge with no slave selected");

  chk_recv_event: assert property (p_recv_publish)
    else $error("received byte not published with event and flag");

  chk_dst_step: assert property (rx_full_event_o |-> dst_index_o == 16'($past(dst_index_o) + 16'h0001))
    else $error("destination index did not advance by one");

  chk_src_step: assert property (tx_empty_event_o |-> src_index_o == 16'($past(src_index_o) + 16'h0001))
    else $error("source index did not advance by one");

  chk_empty_stall: assert property ((state == spi_engine_pkg::ST_LOAD && bytes_left != '0 &&
                                     !cur.is_read && !fifo_valid) |=> state == spi_engine_pkg::ST_LOAD && !sck_o)
    else $error("byte loaded from an empty buffer");

  chk_eight_pulses: assert property (byte_end |-> rise_cnt == 4'h8)
    else $error("byte did not span eight clock pulses");

  chk_exact_count: assert property (done_o |-> &sel_n_o &&
                                    (cur.is_read ? dst_index_o : src_index_o) == cur.count)
    else $error("transfer ended with wrong byte count");

endmodule

// >>> test/spi_master_byte_transfer_tb.sv
// Self-checking bench for the byte transfer engine against a behavioural serial slave
module spi_master_byte_transfer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clock_i     = 1'b0;
  logic                 sys_rst_i   = 1'b1;
  logic                 cmd_valid_i = 1'b0;
  spi_engine_pkg::cmd_t cmd_i       = '0;
  logic [7:0]           tx_data_i   = 8'h00;
  logic                 tx_valid_i  = 1'b0;
  logic                 recv_take_i = 1'b0;
  logic                 cmd_ready_o, done_o, tx_ready_o, tx_empty_event_o, tx_space_flag_o;
  logic                 rx_full_event_o, rx_byte_flag_o, sck_o, mosi_o, miso_i;
  logic                 sck_q       = 1'b0;
  logic [7:0]           recv_data_o, wire_byte;
  logic [15:0]          src_index_o, dst_index_o, wire_cnt;
  logic [15:0]          rnd         = 16'h8968;
  logic [15:0]          exp_src     = 16'h0000;
  logic [23:0]          rx_note;
  logic [3:0]           sel_n_o;
  logic [1:0]           cur_slave   = 2'h0;
  logic [7:0]           exp_wire[$];
  logic [23:0]          exp_rx[$];
  int                   fail_count  = 0;
  int                   n_checks    = 0;
  int                   sck_rises   = 0;
  int                   i, n;

  always #5 clock_i = ~clock_i;

  spi_byte_engine #(.NUM_SLAVES(4), .HALF_CYCLES(8), .FIFO_DEPTH(8)) i_spi_byte_engine (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_empty_event_o(tx_empty_event_o), .tx_space_flag_o(tx_space_flag_o),
    .recv_data_o(recv_data_o), .rx_full_event_o(rx_full_event_o), .rx_byte_flag_o(rx_byte_flag_o),
    .recv_take_i(recv_take_i), .src_index_o(src_index_o), .dst_index_o(dst_index_o), .sck_o(sck_o),
    .mosi_o(mosi_o), .miso_i(miso_i), .sel_n_o(sel_n_o));
  spi_slave_model i_spi_slave_model (.sck_i(sck_o), .sel_n_i(sel_n_o), .mosi_i(mosi_o), .miso_o(miso_i),
    .byte_o(wire_byte), .byte_cnt_o(wire_cnt));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] next_rnd(input logic [15:0] v);
    logic [15:0] x;
    x = v ^ (v << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic timeout();
    check(16'h0000, 16'h0001);
    finish_test();
  endtask
  task automatic send_cmd(input logic rd, input logic [1:0] s, input logic [15:0] cnt);
    for (int j = 0; j < 200 && cmd_ready_o !== 1'b1; j++) tick();
    if (cmd_ready_o !== 1'b1) timeout();
    cur_slave = s;
    exp_src = 16'h0000;
    cmd_i = '{is_read: rd, slave: s, count: cnt};
    cmd_valid_i = 1'b1;
    tick();
    cmd_valid_i = 1'b0;
  endtask
  task automatic read_cmd(input logic [1:0] s, input logic [15:0] cnt);
    for (int j = 0; j < int'(cnt); j++) begin
      exp_wire.push_back(8'hFF);
      exp_rx.push_back({8'(8'hC3 + j), 16'(j + 1)});
    end
    send_cmd(1'b1, s, cnt);
  endtask
  // Pushes while the buffer accepts, up to max bytes; valid stays up between pushes
  task automatic fill_fifo(input int max);
    for (int j = 0; j < max && tx_ready_o === 1'b1; j++) begin
      rnd = next_rnd(rnd);
      tx_data_i = rnd[7:0];
      tx_valid_i = 1'b1;
      exp_wire.push_back(rnd[7:0]);
      tick();
    end
    tx_valid_i = 1'b0;
  endtask
  // Takes each received byte as soon as it shows
  task automatic wait_done();
    for (int j = 0; j < 20000 && done_o !== 1'b1; j++) begin
      recv_take_i = rx_byte_flag_o;
      tick();
    end
    recv_take_i = 1'b0;
    if (done_o !== 1'b1) timeout();
    check(16'(sel_n_o), 16'h000F);
    check(16'(exp_wire.size()), 16'h0000);
    check(16'(exp_rx.size()), 16'h0000);
    tick();
  endtask

  // ------------------------------------------------------------
  // Result watchers: the receive and wire watchers take the oldest note when a result appears
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    sck_q <= sck_o;
    if (sck_o === 1'b1 && sck_q === 1'b0) begin
      sck_rises <= sck_rises + 1;
      check({12'h000, ~sel_n_o}, 16'(4'h1 << cur_slave));
    end
    if (tx_empty_event_o === 1'b1) begin
      exp_src = exp_src + 16'h0001;
      check(src_index_o, exp_src);
      check(16'(tx_space_flag_o), 16'h0001);
    end
    if (rx_full_event_o === 1'b1) begin
      rx_note = exp_rx.pop_front();
      check(16'(recv_data_o), 16'(rx_note[23:16]));
      check(dst_index_o, rx_note[15:0]);
      check(16'(rx_byte_flag_o), 16'h0001);
    end
  end
  always @(wire_cnt) begin
    if (wire_cnt != 16'h0000) check(16'(wire_byte), 16'(exp_wire.pop_front()));
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) tick();
    sys_rst_i = 1'b0;
    check(16'({cmd_ready_o, tx_ready_o, tx_space_flag_o, mosi_o, sel_n_o, rx_byte_flag_o, done_o, sck_o}),
          16'h07F8);
    // Buffer filled until it refuses, then a write of ten that runs it dry
    fill_fifo(20);
    check(16'(exp_wire.size()), 16'h0008);
    check(16'(tx_space_flag_o), 16'h0000);
    send_cmd(1'b0, 2'h1, 16'h000A);
    for (i = 0; i < 3000 && src_index_o !== 16'h0008; i++) tick();
    if (src_index_o !== 16'h0008) timeout();
    repeat (200) tick();
    n = sck_rises;
    repeat (40) tick();
    check(16'(sck_rises - n), 16'h0000);
    fill_fifo(2);
    wait_done();
    check(exp_src, 16'h000A);
    // Read of three with the first byte left untaken for a while
    read_cmd(2'h2, 16'h0003);
    for (i = 0; i < 3000 && rx_byte_flag_o !== 1'b1; i++) tick();
    if (rx_byte_flag_o !== 1'b1) timeout();
    n = sck_rises;
    repeat (60) tick();
    check(16'(sck_rises - n), 16'h0000);
    check(16'(rx_byte_flag_o), 16'h0001);
    wait_done();
    check(dst_index_o, 16'h0003);
    // Empty write: select only, no serial clock
    n = sck_rises;
    send_cmd(1'b0, 2'h3, 16'h0000);
    wait_done();
    check(16'(sck_rises - n), 16'h0000);
    read_cmd(2'h0, 16'h0001);
    wait_done();
    finish_test();
  end
endmodule

// >>> test/spi_slave_model.sv
// Behavioural serial slave: answers on the slave-out line and records each byte seen on the master-out line
module spi_slave_model (
  input  wire logic        sck_i,
  input  wire logic [3:0]  sel_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic      [7:0]  byte_o,
  output logic      [15:0] byte_cnt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic        selected;
  logic      [7:0]  shift_in;
  logic      [7:0]  r;
  logic      [7:0]  k;
  logic      [2:0]  bits;
  assign selected = ~&sel_n_i;
  initial begin
    miso_o = 1'b0;
    byte_o = 8'h00;
    byte_cnt_o = 16'h0000;
    shift_in = 8'h00;
    k = 8'h00;
    bits = 3'h0;
  end
  // ------------------------------------------------------------
  // Reply k of a selection is 0xC3 + k, whatever arrives on the master-out line
  // ------------------------------------------------------------
  always @(posedge selected) begin
    bits = 3'h0;
    k = 8'h00;
    r = 8'hC3;
    miso_o = r[7];
  end
  always @(posedge sck_i) begin
    if (selected) begin
      shift_in = {shift_in[6:0], mosi_i};
      bits = bits + 3'h1;
      if (bits == 3'h0) begin
        byte_o = shift_in;
        k = k + 8'h01;
        byte_cnt_o = byte_cnt_o + 16'h0001;
      end
    end
  end
  always @(negedge sck_i) begin
    if (selected) begin
      r = 8'hC3 + k;
      miso_o = r[~bits];
    end
  end
  // A released line must not keep showing the last bit
  always @(negedge selected) miso_o = ~miso_o;
endmodule
